// [inc/lgbm_pkg.sv]
// constants and types for the luma gamma and brightness monitor
package lgbm_pkg;
    // ************************************************************
    // register map (serial port subaddresses)
    // ************************************************************
    localparam int          NPTS        = 7;
    localparam int          NGREG       = 14;
    localparam logic [5:0]  SUB_GAMMA0  = 6'h26;
    localparam logic [5:0]  SUB_NGREG   = 6'h0e;
    localparam logic [5:0]  SUB_BRIGHT  = 6'h34;
    localparam logic [5:0]  SUB_OCLK    = 6'h35;
    localparam logic [7:0]  OCLK_RESET  = 8'h70;
    localparam int          OCLK_EN_BIT = 1;
    localparam logic [7:0]  RD_UNMAPPED = 8'h00;
    // reset curve is the identity line through the seven points
    localparam logic [7:0]  GAMMA_RST [NPTS] = '{8'h20, 8'h40, 8'h60, 8'h80,
                                                 8'ha0, 8'hc0, 8'he0};

    // ************************************************************
    // curve knots
    // ************************************************************
    localparam logic [7:0]  FIX_Y0      = 8'h00;
    localparam logic [7:0]  FIX_Y16     = 8'h10;
    localparam logic [7:0]  FIX_Y240    = 8'hf0;
    localparam logic [7:0]  FIX_Y255    = 8'hff;
    localparam logic [7:0]  KX_0        = 8'h00;
    localparam logic [7:0]  KX_16       = 8'h10;
    localparam logic [7:0]  KX_32       = 8'h20;
    localparam logic [7:0]  KX_128      = 8'h80;
    localparam logic [7:0]  KX_224      = 8'he0;
    localparam logic [7:0]  KX_240      = 8'hf0;
    localparam logic [7:0]  KX_255      = 8'hff;
    localparam logic [3:0]  SEG_LOW0    = 4'h0;
    localparam logic [3:0]  SEG_LOW1    = 4'h1;
    localparam logic [3:0]  SEG_TOP     = 4'h8;
    localparam logic [3:0]  SEG_TAIL    = 4'h9;
    localparam int          SH_NARROW   = 4;
    localparam int          SH_WIDE     = 5;
    localparam int          MID_PT      = 3;

    // ************************************************************
    // brightness averager
    // ************************************************************
    localparam int          SUM_W       = 28;
    localparam int          CNT_W       = 20;
    localparam logic [2:0]  BIT_TOP     = 3'h7;
    localparam logic [2:0]  BIT_LAST    = 3'h0;
    localparam int          DIV_CYCLES  = 8;

    typedef enum logic {BR_IDLE, BR_DIV} lgbm_br_state_t;
endpackage : lgbm_pkg

// [inc/lgbm_stream_if.sv]
// valid/ready pixel stream carrying one luma and one chroma byte
`timescale 1ns/1ps
interface lgbm_stream_if;
    logic       valid;
    logic       ready;
    logic [7:0] luma;
    logic [7:0] chroma;
    modport src (output valid, output luma, output chroma, input ready);
    modport snk (input valid, input luma, input chroma, output ready);
endinterface : lgbm_stream_if

// [hw/lgbm_skid_buf.sv]
// two-entry skid buffer; every downstream output and up.ready come from flops
`timescale 1ns/1ps
module lgbm_skid_buf (
    input  wire logic   clk_in,
    input  wire logic   rstn_in,
    input  wire logic   ce_in,
    lgbm_stream_if.snk  up,
    lgbm_stream_if.src  dn
);
    logic       out_v_q;
    logic [7:0] out_l_q;
    logic [7:0] out_c_q;
    logic       sk_v_q;
    logic [7:0] sk_l_q;
    logic [7:0] sk_c_q;
    logic       rdy_q;
    wire        take     = up.valid & rdy_q;
    wire        slot_free = ~out_v_q | dn.ready;
    wire        to_skid  = take & ~slot_free;
    wire        sk_v_d   = slot_free ? 1'b0 : (sk_v_q | to_skid);

    assign up.ready  = rdy_q;
    assign dn.valid  = out_v_q;
    assign dn.luma   = out_l_q;
    assign dn.chroma = out_c_q;

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            out_v_q <= 1'b0;
            out_l_q <= 8'h00;
            out_c_q <= 8'h00;
            sk_v_q  <= 1'b0;
            sk_l_q  <= 8'h00;
            sk_c_q  <= 8'h00;
            rdy_q   <= 1'b0;
        end else if (ce_in) begin
            // a word in the skid always leaves before a new one is taken
            if (slot_free) begin
                out_v_q <= sk_v_q | take;
                out_l_q <= sk_v_q ? sk_l_q : up.luma;
                out_c_q <= sk_v_q ? sk_c_q : up.chroma;
            end
            if (to_skid) begin
                sk_l_q <= up.luma;
                sk_c_q <= up.chroma;
            end
            sk_v_q <= sk_v_d;
            rdy_q  <= ~sk_v_d;
        end
    end
endmodule : lgbm_skid_buf

// [hw/lgbm_top.sv]
// luma gamma curve, per-field average brightness monitor and clock pin gate
`timescale 1ns/1ps
module lgbm_top (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       ce_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [5:0] reg_subaddr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    output logic            reg_rvalid_out,
    input  wire logic       pix_valid_in,
    output logic            pix_ready_out,
    input  wire logic [7:0] luma_in,
    input  wire logic [7:0] chroma_in,
    input  wire logic       active_in,
    input  wire logic       vsync_n_in,
    input  wire logic       curve_b_sel_in,
    output logic            pix_valid_out,
    input  wire logic       pix_ready_in,
    output logic      [7:0] luma_out,
    output logic      [7:0] chroma_out,
    input  wire logic       pll_disable_in,
    input  wire logic       oversample_en_in,
    input  wire logic       pll_clk54_in,
    output logic            pll_clock_pin_out
);
    // ************************************************************
    // register file
    // ************************************************************
    logic [7:0] gamma_q [lgbm_pkg::NGREG];
    logic [7:0] ocr_q;
    logic [7:0] bright_q;
    logic [7:0] rdata_q;
    logic       rvalid_q;

    wire [5:0] g_idx = reg_subaddr_in - lgbm_pkg::SUB_GAMMA0;
    wire       g_hit = (reg_subaddr_in >= lgbm_pkg::SUB_GAMMA0) && (g_idx < lgbm_pkg::SUB_NGREG);
    wire [7:0] rd_mux = g_hit ? gamma_q[g_idx[3:0]] :
                        (reg_subaddr_in == lgbm_pkg::SUB_BRIGHT) ? bright_q :
                        (reg_subaddr_in == lgbm_pkg::SUB_OCLK) ? ocr_q : lgbm_pkg::RD_UNMAPPED;
    wire       ocr_wr = reg_wr_in && (reg_subaddr_in == lgbm_pkg::SUB_OCLK);

    genvar gi;
    generate
        for (gi = 0; gi < lgbm_pkg::NGREG; gi++) begin : g_greg
            wire wr = reg_wr_in && g_hit && (g_idx == 6'(gi));
            always_ff @(posedge clk_in) begin
                if (!rstn_in) begin
                    gamma_q[gi] <= lgbm_pkg::GAMMA_RST[gi % lgbm_pkg::NPTS];
                end else if (ce_in && wr) begin
                    gamma_q[gi] <= reg_wdata_in;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ocr_q    <= lgbm_pkg::OCLK_RESET;
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else if (ce_in) begin
            if (ocr_wr) begin
                ocr_q <= reg_wdata_in;
            end
            if (reg_rd_in) begin
                rdata_q <= rd_mux;
            end
            rvalid_q <= reg_rd_in;
        end
    end
    assign reg_rdata_out  = rdata_q;
    assign reg_rvalid_out = rvalid_q;

    // ************************************************************
    // gamma curve
    // ************************************************************
    // ten knots at x = 0,16,32,64..224,240; the 240..255 tail is fixed
    logic [7:0] knot_y [10];
    assign knot_y[0] = lgbm_pkg::FIX_Y0;
    assign knot_y[1] = lgbm_pkg::FIX_Y16;
    assign knot_y[9] = lgbm_pkg::FIX_Y240;
    generate
        for (gi = 0; gi < lgbm_pkg::NPTS; gi++) begin : g_knot
            // the select swaps whole curves, so the two never mix
            assign knot_y[gi + 2] = curve_b_sel_in ? gamma_q[gi + lgbm_pkg::NPTS]
                                                   : gamma_q[gi];
        end
    endgenerate

    wire [3:0] seg = (luma_in < lgbm_pkg::KX_16)  ? lgbm_pkg::SEG_LOW0 :
                     (luma_in < lgbm_pkg::KX_32)  ? lgbm_pkg::SEG_LOW1 :
                     (luma_in < lgbm_pkg::KX_224) ? ({1'b0, luma_in[7:5]} + 4'h1) :
                     (luma_in < lgbm_pkg::KX_240) ? lgbm_pkg::SEG_TOP : lgbm_pkg::SEG_TAIL;
    wire [7:0] x_lo = (seg == lgbm_pkg::SEG_LOW0) ? lgbm_pkg::KX_0 :
                      (seg == lgbm_pkg::SEG_LOW1) ? lgbm_pkg::KX_16 :
                      (seg == lgbm_pkg::SEG_TOP)  ? lgbm_pkg::KX_224 : {luma_in[7:5], 5'h00};
    wire       wide = (seg != lgbm_pkg::SEG_LOW0) && (seg != lgbm_pkg::SEG_LOW1) &&
                      (seg != lgbm_pkg::SEG_TOP);
    wire [3:0] seg_hi = (seg == lgbm_pkg::SEG_TAIL) ? seg : seg + 4'h1;
    wire [7:0] y_lo = knot_y[seg];
    wire [7:0] y_hi = knot_y[seg_hi];
    wire [7:0] dx   = luma_in - x_lo;
    wire signed [8:0]  dy   = $signed({1'b0, y_hi}) - $signed({1'b0, y_lo});
    wire signed [15:0] prod = dy * $signed({1'b0, dx[5:0]});
    wire signed [15:0] step = wide ? (prod >>> lgbm_pkg::SH_WIDE) : (prod >>> lgbm_pkg::SH_NARROW);
    // floor division keeps the result between the two knot values
    wire signed [15:0] y_int = $signed({8'h00, y_lo}) + step;
    wire [7:0] tail  = luma_in - lgbm_pkg::KX_240 + lgbm_pkg::FIX_Y240;
    wire [7:0] g_out = (seg == lgbm_pkg::SEG_TAIL) ? tail : y_int[7:0];

    lgbm_stream_if up_if ();
    lgbm_stream_if dn_if ();
    assign up_if.valid  = pix_valid_in;
    assign up_if.luma   = g_out;
    assign up_if.chroma = chroma_in;
    assign pix_ready_out = up_if.ready;
    assign dn_if.ready  = pix_ready_in;
    assign pix_valid_out = dn_if.valid;
    assign luma_out      = dn_if.luma;
    assign chroma_out    = dn_if.chroma;

    lgbm_skid_buf u_buf (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .ce_in   (ce_in),
        .up      (up_if.snk),
        .dn      (dn_if.src)
    );

    // ************************************************************
    // brightness monitor
    // ************************************************************
    lgbm_pkg::lgbm_br_state_t st_q;
    logic                      vs_q;
    logic [lgbm_pkg::SUM_W-1:0] sum_q;
    logic [lgbm_pkg::CNT_W-1:0] cnt_q;
    logic [lgbm_pkg::SUM_W-1:0] rem_q;
    logic [lgbm_pkg::CNT_W-1:0] dcnt_q;
    logic [7:0]                quo_q;
    logic [2:0]                bit_q;

    wire vs_fall = vs_q & ~vsync_n_in;
    wire acc     = pix_valid_in & pix_ready_out & active_in;
    wire [lgbm_pkg::SUM_W-1:0] acc_l = acc ? {20'h00000, luma_in} : '0;
    wire [lgbm_pkg::SUM_W-1:0] trial = {8'h00, dcnt_q} << bit_q;
    wire       ge    = (rem_q >= trial) && (dcnt_q != '0);
    wire [7:0] quo_d = quo_q | (ge ? (8'h01 << bit_q) : 8'h00);
    wire       done  = (st_q == lgbm_pkg::BR_DIV) && (bit_q == lgbm_pkg::BIT_LAST);

    // long division needs only eight steps since an average never exceeds 255
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            st_q <= lgbm_pkg::BR_IDLE;
            vs_q <= 1'b1;
            sum_q <= '0;
            cnt_q <= '0;
            rem_q <= '0;
            dcnt_q <= '0;
            quo_q <= 8'h00;
            bit_q <= lgbm_pkg::BIT_TOP;
            bright_q <= 8'h00;
        end else if (ce_in) begin
            vs_q <= vsync_n_in;
            if (vs_fall) begin
                rem_q  <= sum_q;
                dcnt_q <= cnt_q;
                sum_q  <= acc_l;
                cnt_q  <= {19'h0, acc};
                quo_q  <= 8'h00;
                bit_q  <= lgbm_pkg::BIT_TOP;
                st_q   <= lgbm_pkg::BR_DIV;
            end else begin
                sum_q <= sum_q + acc_l;
                cnt_q <= cnt_q + {19'h0, acc};
                case (st_q)
                    lgbm_pkg::BR_DIV: begin
                        rem_q <= ge ? rem_q - trial : rem_q;
                        quo_q <= quo_d;
                        bit_q <= bit_q - 3'h1;
                        if (done) begin
                            bright_q <= quo_d;
                            st_q     <= lgbm_pkg::BR_IDLE;
                        end
                    end
                    default: st_q <= lgbm_pkg::BR_IDLE;
                endcase
            end
        end
    end

    // ************************************************************
    // clock pin gate
    // ************************************************************
    logic pin_q;
    wire  pin_en = ocr_q[lgbm_pkg::OCLK_EN_BIT] & ~pll_disable_in & oversample_en_in;
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pin_q <= 1'b0;
        end else if (ce_in) begin
            pin_q <= pin_en & pll_clk54_in;
        end
    end
    assign pll_clock_pin_out = pin_q;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_gwrite;
        ce_in && reg_wr_in && reg_subaddr_in == lgbm_pkg::SUB_GAMMA0;
    endsequence
    sequence s_nowrite;
        !reg_wr_in;
    endsequence
    sequence s_gread;
        ce_in && reg_rd_in && !reg_wr_in && reg_subaddr_in == lgbm_pkg::SUB_GAMMA0;
    endsequence
    sequence s_fall;
        ce_in && vs_fall;
    endsequence

    gamma_readback_a: assert property (
        s_gwrite ##1 s_nowrite ##1 s_gread |=> reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("gamma register readback mismatch");
    chroma_pass_a: assert property (
        ce_in && pix_valid_in && pix_ready_out && (!pix_valid_out || pix_ready_in) |=>
        chroma_out == $past(chroma_in))
        else $error("chroma altered by gamma path");
    curve_mid_a: assert property (
        pix_valid_in && luma_in == lgbm_pkg::KX_128 |-> up_if.luma == (curve_b_sel_in ?
        gamma_q[lgbm_pkg::MID_PT + lgbm_pkg::NPTS] : gamma_q[lgbm_pkg::MID_PT]))
        else $error("mid knot not taken from selected curve");
    fixed_points_a: assert property (
        pix_valid_in && (luma_in == lgbm_pkg::KX_16 || luma_in == lgbm_pkg::KX_255 ||
        luma_in == lgbm_pkg::KX_0 || luma_in == lgbm_pkg::KX_240) |->
        up_if.luma == ((luma_in == lgbm_pkg::KX_16) ? lgbm_pkg::FIX_Y16 :
                       (luma_in == lgbm_pkg::KX_240) ? lgbm_pkg::FIX_Y240 :
                       (luma_in == lgbm_pkg::KX_0) ? lgbm_pkg::FIX_Y0 : lgbm_pkg::FIX_Y255))
        else $error("fixed curve point altered");
    interp_range_a: assert property (
        pix_valid_in && seg != lgbm_pkg::SEG_TAIL |->
        (up_if.luma >= y_lo && up_if.luma <= y_hi) || (up_if.luma <= y_lo && up_if.luma >= y_hi))
        else $error("interpolated luma outside its segment");
    avg_update_a: assert property (
        s_fall ##1 (ce_in && !vs_fall) [*8] |=> st_q == lgbm_pkg::BR_IDLE &&
        bright_q == $past(quo_d))
        else $error("average not updated after vsync fall");
    avg_hold_a: assert property (
        !(ce_in && done) |=> bright_q == $past(bright_q))
        else $error("average changed outside an update");
    active_only_a: assert property (
        ce_in && !active_in && !vs_fall |=> sum_q == $past(sum_q))
        else $error("blanking luma accumulated");
    pin_gate_a: assert property (
        ce_in && (pll_disable_in || !oversample_en_in) |=> !pll_clock_pin_out)
        else $error("clock pin driven while PLL path off");
    pin_drive_a: assert property (
        ce_in && pin_en && pll_clk54_in |=> pll_clock_pin_out)
        else $error("clock pin not driven while enabled");
endmodule : lgbm_top

// [dv/lgbm_host_model.sv]
// host model that programs and reads registers over the strobe port
`timescale 1ns/1ps
module lgbm_host_model (
    input  wire logic       clk_in,
    output logic            reg_wr_out,
    output logic            reg_rd_out,
    output logic      [5:0] reg_subaddr_out,
    output logic      [7:0] reg_wdata_out,
    input  wire logic [7:0] reg_rdata_in,
    input  wire logic       reg_rvalid_in
);
    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_subaddr_out = 6'h3f;
        reg_wdata_out = 8'h00;
    end

    // point value of a power-law curve, kept inside the legal output span
    function automatic logic [7:0] curve_point(input int x, input real g);
        int y;
        y = $rtoi((((x - 16) / 224.0) ** g) * 224.0 + 16.5);
        if (y < 16) y = 16;
        if (y > 240) y = 240;
        return y[7:0];
    endfunction : curve_point

    task automatic write_reg(input logic [5:0] sub, input logic [7:0] d);
        @(posedge clk_in);
        reg_wr_out <= 1'b1;
        reg_subaddr_out <= sub;
        reg_wdata_out <= d;
        @(posedge clk_in);
        reg_wr_out <= 1'b0;
        // released bus shows no stale value
        reg_subaddr_out <= ~sub;
        reg_wdata_out <= ~d;
    endtask : write_reg

    task automatic read_reg(input logic [5:0] sub, output logic [7:0] d, output logic ok);
        @(posedge clk_in);
        reg_rd_out <= 1'b1;
        reg_subaddr_out <= sub;
        @(posedge clk_in);
        reg_rd_out <= 1'b0;
        reg_subaddr_out <= ~sub;
        ok = 1'b0;
        d = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk_in);
            if (reg_rvalid_in === 1'b1) begin
                ok = 1'b1;
                d = reg_rdata_in;
            end
        end
    endtask : read_reg

    // reserved bits always written with their fixed values
    task automatic set_clock_pin(input logic en);
        write_reg(lgbm_pkg::SUB_OCLK, {4'h7, 2'h0, en, 1'b0});
    endtask : set_clock_pin
endmodule : lgbm_host_model

// [dv/tb.sv]
// self-checking bench for the gamma, brightness and clock pin block
`timescale 1ns/1ps
module tb;
    logic       clk_in, rstn_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
    logic [5:0] reg_subaddr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out, luma_in, chroma_in, luma_out, chroma_out;
    logic       pix_valid_in, pix_ready_out, active_in, vsync_n_in, curve_b_sel_in;
    logic       pix_valid_out, pix_ready_in, pll_disable_in, oversample_en_in;
    logic       pll_clk54_in, pll_clock_pin_out, ce_in;
    logic [7:0] pts [14];
    logic [7:0] corner [8] = '{8'h00, 8'h10, 8'h1f, 8'h20, 8'he0, 8'hef, 8'hf0, 8'hff};
    logic [15:0] e;
    logic [15:0] exp_q [$];
    int         bad_count, checks, cycles, bsum, bcnt;

    lgbm_top uut (.clk_in, .rstn_in, .ce_in, .reg_wr_in, .reg_rd_in, .reg_subaddr_in,
        .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .pix_valid_in, .pix_ready_out,
        .luma_in, .chroma_in, .active_in, .vsync_n_in, .curve_b_sel_in, .pix_valid_out,
        .pix_ready_in, .luma_out, .chroma_out, .pll_disable_in, .oversample_en_in,
        .pll_clk54_in, .pll_clock_pin_out);
    lgbm_host_model host (.clk_in, .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
        .reg_subaddr_out(reg_subaddr_in), .reg_wdata_out(reg_wdata_in),
        .reg_rdata_in(reg_rdata_out), .reg_rvalid_in(reg_rvalid_out));

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    // ************************************************************
    // expectation and comparison helpers
    // ************************************************************
    function automatic logic [7:0] gamma_exp(input logic [7:0] x, input logic sel);
        int kx [11] = '{0, 16, 32, 64, 96, 128, 160, 192, 224, 240, 255};
        int ky [11] = '{0, 16, 0, 0, 0, 0, 0, 0, 0, 240, 255};
        int k, num, q;
        for (k = 0; k < 7; k++) ky[k + 2] = pts[sel * 7 + k];
        k = 0;
        while (k < 9 && x >= kx[k + 1]) k++;
        num = (ky[k + 1] - ky[k]) * (x - kx[k]);
        q = num / (kx[k + 1] - kx[k]);
        if (num < 0 && q * (kx[k + 1] - kx[k]) != num) q--;
        return 8'(ky[k] + q);
    endfunction : gamma_exp

    task automatic chk8(input string what, input logic [7:0] ex, input logic [7:0] got);
        checks++;
        if (got !== ex) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, ex, got);
        end
    endtask : chk8

    task automatic chk1(input string what, input logic ex, input logic got);
        checks++;
        if (got !== ex) begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", what, ex, got);
        end
    endtask : chk1

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    task automatic read_chk(input string what, input logic [5:0] sub, input logic [7:0] ex);
        logic [7:0] d;
        logic       ok;
        host.read_reg(sub, d, ok);
        chk1("read_answer", 1'b1, ok);
        chk8(what, ex, d);
    endtask : read_chk

    // ready_odds: out of four, how often the sink is ready
    task automatic run_stream(input int n, input int ready_odds);
        for (int c = 0; c < n; c++) begin
            @(posedge clk_in);
            pix_ready_in <= ($urandom % 4) < ready_odds;
            if (!pix_valid_in || pix_ready_out) begin
                pix_valid_in <= ($urandom % 4) != 0;
                luma_in <= ($urandom % 3 == 0) ? corner[$urandom % 8] : 8'($urandom);
                chroma_in <= 8'($urandom);
                active_in <= 1'($urandom);
                curve_b_sel_in <= 1'($urandom);
            end
        end
    endtask : run_stream

    task automatic field_end;
        logic [7:0] ex;
        ex = (bcnt == 0) ? 8'h00 : 8'(bsum / bcnt);
        bsum = 0;
        bcnt = 0;
        @(posedge clk_in) vsync_n_in <= 1'b0;
        @(posedge clk_in) vsync_n_in <= 1'b1;
        repeat (12) @(posedge clk_in);
        read_chk("brightness", lgbm_pkg::SUB_BRIGHT, ex);
    endtask : field_end

    // scoreboard, brightness sums and hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run;
        end
        if (rstn_in && pix_valid_in && pix_ready_out) begin
            exp_q.push_back({chroma_in, gamma_exp(luma_in, curve_b_sel_in)});
            if (active_in) begin
                bsum += luma_in;
                bcnt++;
            end
        end
        if (rstn_in && pix_valid_out && pix_ready_in) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'h0000;
            chk8("luma_out", e[7:0], luma_out);
            chk8("chroma_out", e[15:8], chroma_out);
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        int i;
        {rstn_in, pix_valid_in, pix_ready_in, active_in, curve_b_sel_in} = 5'h00;
        {luma_in, chroma_in, pll_disable_in, oversample_en_in, pll_clk54_in} = 19'h0;
        vsync_n_in = 1'b1;
        ce_in = 1'b1;
        i = $urandom(32'h3afc0367);
        for (i = 0; i < 14; i++) pts[i] = lgbm_pkg::GAMMA_RST[i % 7];
        repeat (3) @(posedge clk_in);
        rstn_in <= 1'b1;
        for (i = 0; i < 14; i++) read_chk("gamma_reset", 6'(lgbm_pkg::SUB_GAMMA0 + i), pts[i]);
        read_chk("clock_reg_reset", lgbm_pkg::SUB_OCLK, 8'h70);
        // a write while the enable is low must leave the clock register frozen
        ce_in <= 1'b0;
        host.write_reg(lgbm_pkg::SUB_OCLK, 8'h72);
        ce_in <= 1'b1;
        read_chk("frozen_write", lgbm_pkg::SUB_OCLK, 8'h70);
        read_chk("unmapped", 6'h3f, 8'h00);
        host.write_reg(lgbm_pkg::SUB_BRIGHT, 8'h5a);
        read_chk("brightness_ro", lgbm_pkg::SUB_BRIGHT, 8'h00);
        for (i = 0; i < 7; i++) pts[i] = host.curve_point(32 * (i + 1), 0.5);
        for (i = 7; i < 14; i++) pts[i] = 8'(16 + $urandom % 225);
        host.write_reg(lgbm_pkg::SUB_GAMMA0, 8'h5a);
        read_chk("gamma_back_to_back", lgbm_pkg::SUB_GAMMA0, 8'h5a);
        for (i = 0; i < 14; i++) host.write_reg(6'(lgbm_pkg::SUB_GAMMA0 + i), pts[i]);
        for (i = 0; i < 14; i++) read_chk("gamma_point", 6'(lgbm_pkg::SUB_GAMMA0 + i), pts[i]);
        run_stream(300, 3);
        run_stream(20, 0);
        #1;
        chk1("stall_refuse", 1'b0, pix_ready_out);
        run_stream(100, 4);
        do @(posedge clk_in); while (pix_valid_in && !pix_ready_out);
        pix_valid_in <= 1'b0;
        pix_ready_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        chk1("stream_drained", 1'b1, exp_q.size() == 0);
        field_end();
        field_end();
        for (i = 0; i < 8; i++) begin
            host.set_clock_pin(i[0]);
            pll_disable_in <= i[1];
            oversample_en_in <= i[2];
            repeat (6) begin
                @(posedge clk_in) pll_clk54_in <= 1'($urandom);
                @(posedge clk_in);
                #1;
                chk1("clock_pin", i[0] & !i[1] & i[2] & pll_clk54_in, pll_clock_pin_out);
            end
        end
        complete_run();
    end
endmodule : tb
